// ===== core/sac_consts.svh
// Constants of the serial converter control sequencer.
// Assumes inclusion by bare name; definitions only.
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// Result width and derived last bit index
`define SAC_RESULT_W 8
`define SAC_MSB_IDX 3'h7
// Address shift register width: start bit plus two config bits
`define SAC_ADDR_W 3
// Start position in the shift register for the twin variant
`define SAC_START_POS_TWIN 2
// Reset values and first trial word
`define SAC_RESULT_RST 8'h00
`define SAC_TRIAL_FIRST 8'h80
`define SAC_ADDR_RST 3'h0
`define SAC_IDX_RST 3'h0

`endif

// ===== core/sac_pkg.sv
// Types shared by the serial converter control sequencer.
// Assumes sac_consts.svh is on the include path.
`default_nettype none
`include "sac_consts.svh"

package sac_pkg;

  // Sequencer phases within one chip-select frame
  typedef enum logic [2:0] {
    SAC_IDLE,
    SAC_ADDR,
    SAC_SETTLE,
    SAC_RESOLVE,
    SAC_LSB,
    SAC_DONE
  } sac_state_e;

  // Negative terminal choice of the input multiplexer
  typedef enum logic [1:0] {
    SAC_NEG_NONE,
    SAC_NEG_ZERO,
    SAC_NEG_ONE,
    SAC_NEG_GROUND
  } sac_neg_e;

  // Multiplexer routing applied at conversion start
  typedef struct packed {
    logic enabled;
    logic pos_on_input_one;
    sac_neg_e neg_sel;
    logic single_or_differential_bit;
    logic parity_bit;
  } sac_route_s;

  // One two-way data pin seen from the device
  typedef struct packed {
    logic out;
    logic oe;
  } sac_pin_s;

  // Result word with its finished flag
  typedef struct packed {
    logic valid;
    logic [`SAC_RESULT_W-1:0] code;
  } sac_result_s;

endpackage : sac_pkg
`default_nettype wire

// ===== core/sac_sequencer.sv
// Serial control and output sequencer of an 8-bit successive-approximation converter.
// Assumes chip select, serial clock and data in are synchronous to clock (50 MHz),
// and that the analog comparator and trial ladder sit outside this block.
//
// What this block does
// - Chip select low starts a frame; logic runs only while it is low.
// - Exactly one serial clock period of settling follows channel selection.
// - Data out leaves high impedance driving a low for that settling period.
// - Each decided bit is output at once, most significant first.
// - Eight serial clock periods after settling the conversion is complete.
// - Chip select high clears every register except the serial clock history and floats data out.
// - Each serial clock rise while the twin variant is addressing shifts data in into the address register.
// - Twin variant: first high sample after chip select falls is the start bit; single-pair starts on the first rise.
// - Start bit in start position applies the channel and starts converting.
// - Data in is ignored from conversion start until chip select rises.
// - Twin variant repeats the result least significant bit first.
// - Data in sampled only while data out floats, so one wire may serve.
// - Mode bit low: differential with parity polarity; high: single-ended.
// - Positive input below negative input gives an all-zero result.
// - Single-pair variant has fixed polarity and skips addressing.
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"

module sac_sequencer (
  input wire logic clock,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_address_in,
  input wire logic twin_channel_variant,
  input wire logic comparator_high,
  input wire logic negative_above_positive,
  output sac_pkg::sac_pin_s data_pin,
  output logic [`SAC_RESULT_W-1:0] ladder_trial,
  output sac_pkg::sac_route_s mux_route,
  output sac_pkg::sac_result_s result,
  output logic converting
);
  import sac_pkg::*;

  // Multiplexer routing for an assignment word
  function automatic sac_route_s decode_route(
    input logic single_bit,
    input logic parity
  );
    sac_route_s r;
    r.enabled = 1'b1;
    r.single_or_differential_bit = single_bit;
    r.parity_bit = parity;
    r.pos_on_input_one = parity;
    if (single_bit) begin
      r.neg_sel = SAC_NEG_GROUND;
    end else if (parity) begin
      r.neg_sel = SAC_NEG_ZERO;
    end else begin
      r.neg_sel = SAC_NEG_ONE;
    end
    return r;
  endfunction : decode_route

  // One-hot trial bit at a given index
  function automatic logic [`SAC_RESULT_W-1:0] trial_bit(
    input logic [2:0] idx
  );
    trial_bit = `SAC_RESULT_W'(1) << idx;
  endfunction : trial_bit

  // Serial clock history for edge detection
  logic sclk_prev_ff;
  logic sclk_rise;
  logic sclk_fall;

  always_ff @(posedge clock) begin
    if (reset) begin
      sclk_prev_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= serial_clock;
    end
  end

  assign sclk_rise = serial_clock & ~sclk_prev_ff;
  assign sclk_fall = ~serial_clock & sclk_prev_ff;

  // Sequencer state
  sac_state_e state_ff;
  sac_state_e nxt_state;
  logic [`SAC_ADDR_W-1:0] addr_sr_ff;
  logic [`SAC_ADDR_W-1:0] nxt_addr_sr;
  logic [2:0] idx_ff;
  logic [2:0] nxt_idx;
  sac_pin_s pin_ff;
  sac_pin_s nxt_pin;
  logic [`SAC_RESULT_W-1:0] trial_ff;
  logic [`SAC_RESULT_W-1:0] nxt_trial;
  sac_route_s route_ff;
  sac_route_s nxt_route;
  sac_result_s result_ff;
  sac_result_s nxt_result;
  logic busy_ff;
  logic nxt_busy;

  // Bit decided by the comparator at this falling edge
  logic decided_bit;
  logic [`SAC_RESULT_W-1:0] kept_code;
  logic [`SAC_ADDR_W-1:0] shifted_sr;

  // Clamp to zero when the inputs are reversed, whatever the ladder says
  assign decided_bit = comparator_high & ~negative_above_positive;
  assign kept_code = decided_bit ? (result_ff.code | trial_bit(idx_ff))
                                 : (result_ff.code & ~trial_bit(idx_ff));
  assign shifted_sr = {addr_sr_ff[`SAC_ADDR_W-2:0], serial_address_in};

  // Next values for the whole frame
  always_comb begin
    nxt_state = state_ff;
    nxt_addr_sr = addr_sr_ff;
    nxt_idx = idx_ff;
    nxt_pin = pin_ff;
    nxt_trial = trial_ff;
    nxt_route = route_ff;
    nxt_result = result_ff;
    nxt_busy = busy_ff;
    if (chip_select_n) begin
      // Frame over or aborted: everything back to rest, pin floats
      nxt_state = SAC_IDLE;
      nxt_addr_sr = `SAC_ADDR_RST;
      nxt_idx = `SAC_IDX_RST;
      nxt_pin = '0;
      nxt_trial = `SAC_RESULT_RST;
      nxt_route = '0;
      nxt_result = '0;
      nxt_busy = 1'b0;
    end else begin
      unique case (state_ff)
        SAC_IDLE: begin
          // Chip select low in idle is the only way into a frame
          nxt_state = SAC_ADDR;
        end
        SAC_ADDR: begin
          // Pin still floats here, so sampling data in is safe on a shared wire
          if (sclk_rise) begin
            if (!twin_channel_variant) begin
              // Fixed polarity, no assignment word
              nxt_route = decode_route(1'b0, 1'b0);
              nxt_state = SAC_SETTLE;
              nxt_busy = 1'b1;
            end else begin
              nxt_addr_sr = shifted_sr;
              if (shifted_sr[`SAC_START_POS_TWIN]) begin
                // Mode bit arrived first, parity second
                nxt_route = decode_route(shifted_sr[1], shifted_sr[0]);
                nxt_state = SAC_SETTLE;
                nxt_busy = 1'b1;
              end
            end
          end
        end
        SAC_SETTLE: begin
          // Leading low for one serial clock period while the channel settles
          if (sclk_fall) begin
            nxt_pin.oe = 1'b1;
            nxt_pin.out = 1'b0;
            nxt_trial = `SAC_TRIAL_FIRST;
            nxt_idx = `SAC_MSB_IDX;
            nxt_state = SAC_RESOLVE;
          end
        end
        SAC_RESOLVE: begin
          // One bit decided and shifted out per falling edge
          if (sclk_fall) begin
            nxt_result.code = kept_code;
            nxt_pin.out = decided_bit;
            if (idx_ff == `SAC_IDX_RST) begin
              nxt_result.valid = 1'b1;
              nxt_trial = kept_code;
              nxt_busy = 1'b0;
              if (twin_channel_variant) begin
                nxt_idx = 3'h1;
                nxt_state = SAC_LSB;
              end else begin
                nxt_state = SAC_DONE;
              end
            end else begin
              nxt_idx = idx_ff - 3'h1;
              nxt_trial = kept_code | trial_bit(idx_ff - 3'h1);
            end
          end
        end
        SAC_LSB: begin
          // Bit zero is shared, so the reverse stream starts at bit one
          if (sclk_fall) begin
            nxt_pin.out = result_ff.code[idx_ff];
            if (idx_ff == `SAC_MSB_IDX) begin
              nxt_state = SAC_DONE;
            end else begin
              nxt_idx = idx_ff + 3'h1;
            end
          end
        end
        SAC_DONE: begin
          // Data in stays ignored; pin released after the last bit period
          if (sclk_fall) begin
            nxt_pin = '0;
          end
        end
      endcase
    end
  end

  // Registers of the frame; the synchronous reset matches a chip select rise
  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= SAC_IDLE;
      addr_sr_ff <= `SAC_ADDR_RST;
      idx_ff <= `SAC_IDX_RST;
      pin_ff <= '0;
      trial_ff <= `SAC_RESULT_RST;
      route_ff <= '0;
      result_ff <= '0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      addr_sr_ff <= nxt_addr_sr;
      idx_ff <= nxt_idx;
      pin_ff <= nxt_pin;
      trial_ff <= nxt_trial;
      route_ff <= nxt_route;
      result_ff <= nxt_result;
      busy_ff <= nxt_busy;
    end
  end

  // Outputs straight from the registers
  assign data_pin = pin_ff;
  assign ladder_trial = trial_ff;
  assign mux_route = route_ff;
  assign result = result_ff;
  assign converting = busy_ff;

endmodule : sac_sequencer
`default_nettype wire

// ===== verification/sac_ctl_model.sv
// Controller model: chip select, serial clock, data in, comparator.
// Assumes the bench calls frame then finish_frame; driven on falling edges.
`timescale 1ns/1ps
`default_nettype none
module sac_ctl_model (
  input wire logic clock,
  input wire logic [7:0] ladder_trial,
  input wire sac_pkg::sac_pin_s data_pin,
  output logic chip_select_n,
  output logic serial_clock,
  output logic serial_address_in,
  output logic comparator_high
);
  import sac_pkg::*;
  logic [7:0] target = 8'h00;
  sac_pin_s obs [0:23];
  // Ideal comparator, so the finished code equals the target
  assign comparator_high = ladder_trial <= target;
  initial begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_address_in = 1'b0;
  end
  // Slow serial clock: twelve system clocks per period, pin sampled midway through the low phase
  task automatic frame(input logic twin, input int lead, input logic m, input logic p, input int ncyc);
    logic [2:0] word;
    word = twin ? {1'b1, m, p} : 3'h4;
    @(negedge clock) chip_select_n = 1'b0;
    repeat (2) @(negedge clock);
    for (int k = 0; k < ncyc; k++) begin
      if (k < lead) serial_address_in = 1'b0;
      else if (k < lead + 3) serial_address_in = word[2 - (k - lead)];
      else serial_address_in = ~serial_address_in;
      repeat (4) @(negedge clock);
      serial_clock = 1'b1;
      repeat (4) @(negedge clock);
      serial_clock = 1'b0;
      repeat (4) @(negedge clock);
      obs[k] = data_pin;
    end
  endtask : frame
  // A new conversion always needs chip select high first
  task automatic finish_frame();
    @(negedge clock) chip_select_n = 1'b1;
    repeat (2) @(negedge clock);
  endtask : finish_frame
endmodule : sac_ctl_model
`default_nettype wire

// ===== verification/sac_sequencer_chk.sv
// Port-level checks of the converter sequencer.
// Assumes it is bound into sac_sequencer; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module sac_sequencer_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic negative_above_positive,
  input wire sac_pkg::sac_pin_s data_pin,
  input wire logic [7:0] ladder_trial,
  input wire sac_pkg::sac_route_s mux_route,
  input wire sac_pkg::sac_result_s result,
  input wire logic converting
);
  import sac_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // Frame end must clear state on the very next edge
  chk_cs_float_pin: assert property (chip_select_n |=> data_pin == 2'h0) else $error("pin driven");
  chk_cs_clear_all: assert property (chip_select_n |=> result == 9'h0 && !converting) else $error("not cleared");
  chk_settle_low: assert property ($rose(data_pin.oe) |-> !data_pin.out) else $error("no leading low");
  chk_first_trial: assert property ($rose(data_pin.oe) |-> ladder_trial == 8'h80) else $error("bad trial");
  chk_neg_zero: assert property (negative_above_positive && result.valid |-> result.code == 8'h00) else $error("nz");
  chk_conv_route: assert property ($rose(converting) |-> mux_route.enabled) else $error("no route");
  chk_route_hold: assert property (converting && $past(converting) |-> $stable(mux_route)) else $error("moved");
  chk_valid_end: assert property ($fell(converting) && !chip_select_n |-> result.valid) else $error("no valid");
  // Routing must follow the assignment word
  chk_diff_mode: assert property (mux_route.enabled && !mux_route.single_or_differential_bit
    |-> mux_route.neg_sel == (mux_route.parity_bit ? SAC_NEG_ZERO : SAC_NEG_ONE)) else $error("diff");
  chk_se_mode: assert property (mux_route.enabled && mux_route.single_or_differential_bit
    |-> mux_route.neg_sel == SAC_NEG_GROUND && mux_route.pos_on_input_one == mux_route.parity_bit) else $error("se");
endmodule : sac_sequencer_chk
`default_nettype wire

// ===== verification/sac_sequencer_tb_top.sv
// Self-checking bench of the converter sequencer.
// Assumes the controller model drives the serial side.
`timescale 1ns/1ps
`default_nettype none
module sac_sequencer_tb_top;
  import sac_pkg::*;
  logic clock, reset, twin_channel_variant, negative_above_positive;
  logic chip_select_n, serial_clock, serial_address_in, comparator_high, converting;
  logic [7:0] ladder_trial;
  sac_pin_s data_pin;
  sac_route_s mux_route;
  sac_result_s result;
  int failures = 0;
  int n_checks = 0;
  sac_sequencer i_sac_sequencer (.clock, .reset, .chip_select_n, .serial_clock, .serial_address_in,
    .twin_channel_variant, .comparator_high, .negative_above_positive, .data_pin, .ladder_trial,
    .mux_route, .result, .converting);
  sac_ctl_model i_sac_ctl_model (.clock, .ladder_trial, .data_pin, .chip_select_n, .serial_clock,
    .serial_address_in, .comparator_high);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic final_report();
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  // One full frame; expected pin stream built from the settle position s
  task automatic t_frame(input logic twin, input int lead, input logic m, input logic p,
    input logic [7:0] tgt, input logic neg, input logic [5:0] rte);
    int s;
    logic [7:0] code;
    sac_pin_s e;
    s = twin ? lead + 2 : 0;
    code = neg ? 8'h00 : tgt;
    twin_channel_variant = twin;
    negative_above_positive = neg;
    i_sac_ctl_model.target = tgt;
    i_sac_ctl_model.frame(twin, lead, m, p, s + (twin ? 17 : 10));
    for (int k = 0; k < s + (twin ? 17 : 10); k++) begin
      e = 2'h0;
      if (k == s) e = 2'h1;
      else if (k > s && k <= s + 8) e = {code[s + 8 - k], 1'b1};
      else if (twin && k > s + 8 && k <= s + 15) e = {code[k - s - 8], 1'b1};
      cmp("data_pin", {7'h0, e}, {7'h0, i_sac_ctl_model.obs[k]});
    end
    cmp("mux_route", {3'h0, rte}, {3'h0, mux_route});
    cmp("result", {1'b1, code}, result);
    cmp("ladder_trial", {1'b0, code}, {1'b0, ladder_trial});
    i_sac_ctl_model.finish_frame();
    cmp("released", 9'h0, {6'h0, converting, data_pin});
  endtask : t_frame
  // Chip select raised just after the first result bit of a twin frame
  task automatic t_abort();
    twin_channel_variant = 1'b1;
    i_sac_ctl_model.target = 8'hff;
    i_sac_ctl_model.frame(1'b1, 0, 1'b0, 1'b0, 4);
    i_sac_ctl_model.finish_frame();
    cmp("abort_result", 9'h0, result);
    cmp("abort_pin", 9'h0, {1'b0, mux_route, data_pin});
  endtask : t_abort
  // Watchdog cuts a hang short
  initial begin
    repeat (100000) @(posedge clock);
    failures++;
    final_report();
  end
  initial begin
    reset = 1'b1;
    twin_channel_variant = 1'b0;
    negative_above_positive = 1'b0;
    repeat (5) @(negedge clock);
    reset = 1'b0;
    t_frame(1'b1, 0, 1'b0, 1'b0, 8'ha5, 1'b0, 6'h28);
    t_frame(1'b1, 2, 1'b0, 1'b1, 8'h5a, 1'b0, 6'h35);
    t_frame(1'b1, 1, 1'b1, 1'b0, 8'hff, 1'b0, 6'h2e);
    t_frame(1'b1, 0, 1'b1, 1'b1, 8'h01, 1'b0, 6'h3f);
    t_frame(1'b1, 0, 1'b0, 1'b0, 8'hc3, 1'b1, 6'h28);
    t_frame(1'b0, 0, 1'b0, 1'b0, 8'h80, 1'b0, 6'h28);
    t_abort();
    final_report();
  end
endmodule : sac_sequencer_tb_top
bind sac_sequencer sac_sequencer_chk i_sac_sequencer_chk (.clock, .reset, .chip_select_n,
  .negative_above_positive, .data_pin, .ladder_trial, .mux_route, .result, .converting);
`default_nettype wire
